// ---- src/lamp_defs.svh ----
// Timing constants and reset values for the status lamp controller.
// Assumes a single 125 MHz system clock.
`ifndef LAMP_DEFS_SVH
`define LAMP_DEFS_SVH

`define LAMP_CLK_KHZ        125000
`define LAMP_STARTUP_MS     2000
`define LAMP_FLASH_PERIOD_MS 2000
`define LAMP_RST_OFF        1'b0
`define LAMP_RST_ON         1'b1

`endif

// ---- src/lamp_flash_gen.sv ----
// Square wave shared by all flashing lamps.
// Assumes the parent holds it in reset until lamp handling runs.
`timescale 1ns/10ps
`default_nettype none
`include "lamp_defs.svh"

module lamp_flash_gen #(
  parameter int unsigned HALF_CYCLES = 125000000
) (
  input  wire logic clk,
  input  wire logic clk_en,
  input  wire logic clear,
  output logic      flash
);

  localparam int CW = $clog2(HALF_CYCLES + 1);

  logic [CW-1:0] count;

  // 50 percent duty: toggle every half period
  always_ff @(posedge clk) begin
    if (clear) begin
      count <= '0;
      flash <= `LAMP_RST_ON;
    end else if (clk_en) begin
      if (count == CW'(HALF_CYCLES - 1)) begin
        count <= '0;
        flash <= ~flash;
      end else begin
        count <= count + CW'(1);
      end
    end
  end

endmodule

`default_nettype wire

// ---- src/lamp_pkg.sv ----
// Types shared by the status lamp controller, its controller model and its bench.
// Assumes lamp_defs.svh supplies the numeric constants.
package lamp_pkg;

  typedef enum logic [2:0] {
    KIND_MASTER_CAB,
    KIND_EXT_CAB,
    KIND_TRX_UNIT,
    KIND_SLAVE_TX,
    KIND_ENV_UNIT,
    KIND_SUB_UNIT
  } unit_kind_t;

  typedef enum logic [1:0] {
    MODE_LOCAL,
    MODE_REMOTE,
    MODE_TO_LOCAL,
    MODE_TO_REMOTE
  } unit_mode_t;

  typedef enum logic [1:0] {
    OPST_OTHER,
    OPST_A,
    OPST_B,
    OPST_C
  } op_state_t;

  typedef enum logic [1:0] {
    OBJ_CENTRAL,
    OBJ_TRXC,
    OBJ_RX,
    OBJ_TS
  } obj_kind_t;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_STARTUP,
    PH_RUN
  } phase_t;

  typedef struct packed {
    obj_kind_t  kind;
    logic [2:0] trx;
    logic [2:0] ts;
    logic       operational;
  } op_report_t;

  typedef struct packed {
    logic       cfg_in_progress;
    logic       sw_receiving;
    logic       restart_pending;
  } flash_req_t;

  typedef struct packed {
    logic       central_fault_free;
    logic       local_cfg_done;
    logic       sub_fault_free;
    logic       env_operational;
  } local_status_t;

endpackage

// ---- src/unit_status_indicator_control.sv ----
// Operational, transmitter-not-enabled and local-mode lamp control.
// Assumes unit control logic on the same clock supplies mode, state and
// controller reports; only the master lamp level comes from another unit.
//
// Summary of operation
// - Operational lamp off 2-10 s after start
// - Unit reset stops lamps until software restarts
// - Operational lamp on when operational, else off
// - Flash on config, software load, pending restart
// - Flashing beats on, on beats off
// - Remote master cabinet needs all object kinds
// - Remote transceiver needs trxc, rx, one timeslot
// - Slave transmitter lamp mirrors master lamp
// - Objects drop out on reset or local
// - Local master: no class 1, configured
// - Subunit fault free; extension cabinet configured
// - Mode change means not operational
// - Only master cabinet, transceiver and slave transmitter units go remote
// - Environment lamp from local fault state only
// - Reports taken in allowed state, remote only
// - Acceptance message ends the procedure
// - Tx lamp on until transmitter enabled
// - Tx lamp on at disable, software start, auto-disable
// - Local lamp on until mode handling starts
// - Local lamp: on, off, flash on change
// - Link loss in remote not shown
`timescale 1ns/10ps
`default_nettype none
`include "lamp_defs.svh"

module unit_status_indicator_control #(
  parameter int unsigned N_TRX = 8,
  parameter int unsigned N_TS  = 8,
  parameter int unsigned STARTUP_CYCLES =
    `LAMP_STARTUP_MS * `LAMP_CLK_KHZ,
  parameter int unsigned FLASH_HALF_CYCLES =
    (`LAMP_FLASH_PERIOD_MS * `LAMP_CLK_KHZ) / 2
) (
  input  wire logic                   clk,
  input  wire logic                   clk_en,
  input  wire logic                   sys_rst,
  input  wire logic                   unit_reset,
  input  wire logic                   sw_start,
  input  wire lamp_pkg::unit_kind_t   unit_kind,
  input  wire lamp_pkg::unit_mode_t   unit_mode,
  input  wire logic                   mode_handling_started,
  input  wire lamp_pkg::op_state_t    unit_op_state,
  input  wire logic                   report_valid,
  input  wire lamp_pkg::op_report_t   report,
  input  wire logic                   obj_reset_valid,
  input  wire lamp_pkg::op_report_t   obj_reset,
  input  wire lamp_pkg::flash_req_t   flash_req,
  input  wire lamp_pkg::local_status_t local_status,
  input  wire logic [N_TRX-1:0]       trxc_fault_free,
  input  wire logic                   tx_enable,
  input  wire logic                   tx_disable,
  input  wire logic                   master_lamp_in,
  output logic                        op_lamp,
  output logic                        tx_not_enabled_lamp,
  output logic                        local_lamp,
  output logic                        report_accept
);

  localparam int SCW = $clog2(STARTUP_CYCLES + 1);

  lamp_pkg::phase_t             phase;
  logic [SCW-1:0]               start_count;
  logic                         stop;
  logic                         flash;
  logic                         master_sync1;
  logic                         master_sync2;
  logic                         central_ok;
  logic [N_TRX-1:0]             trxc_ok;
  logic [N_TRX-1:0]             rx_ok;
  logic [N_TRX-1:0][N_TS-1:0]   ts_ok;
  lamp_pkg::unit_mode_t         eff_mode;
  logic                         may_go_remote;
  logic                         report_allowed;
  logic                         operational;
  logic                         remote_master_ok;
  logic                         remote_trx_ok;
  logic                         changing;
  logic                         any_flash;

  function automatic logic any_ts(input logic [N_TRX-1:0][N_TS-1:0] t);
    logic r;
    r = 1'b0;
    for (int i = 0; i < N_TRX; i++) begin
      r = r | (|t[i]);
    end
    return r;
  endfunction

  function automatic logic in_range(input logic [2:0] idx,
                                    input int unsigned lim);
    return 32'(idx) < lim;
  endfunction

  assign stop = sys_rst | unit_reset;

  // Link to the neighbouring unit is asynchronous
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      master_sync1 <= 1'b0;
      master_sync2 <= 1'b0;
    end else if (clk_en) begin
      master_sync1 <= master_lamp_in;
      master_sync2 <= master_sync1;
    end
  end

  // Any reset drops to idle; only a software start leaves it
  always_ff @(posedge clk) begin
    if (stop) begin
      phase       <= lamp_pkg::PH_IDLE;
      start_count <= '0;
    end else if (clk_en) begin
      unique case (phase)
        lamp_pkg::PH_IDLE: begin
          if (sw_start) begin
            phase       <= lamp_pkg::PH_STARTUP;
            start_count <= '0;
          end
        end
        lamp_pkg::PH_STARTUP: begin
          // Lamp test ends 2 s after start, within the 2-10 s span
          if (start_count == SCW'(STARTUP_CYCLES - 1)) begin
            phase <= lamp_pkg::PH_RUN;
          end else begin
            start_count <= start_count + SCW'(1);
          end
        end
        lamp_pkg::PH_RUN: begin
        end
      endcase
    end
  end

  lamp_flash_gen #(
    .HALF_CYCLES (FLASH_HALF_CYCLES)
  ) u_flash (
    .clk    (clk),
    .clk_en (clk_en),
    .clear  (phase == lamp_pkg::PH_IDLE),
    .flash  (flash)
  );

  // Environment and subunits never leave local mode
  always_comb begin
    may_go_remote = unit_kind == lamp_pkg::KIND_MASTER_CAB ||
                    unit_kind == lamp_pkg::KIND_TRX_UNIT ||
                    unit_kind == lamp_pkg::KIND_SLAVE_TX;
    eff_mode      = may_go_remote ? unit_mode : lamp_pkg::MODE_LOCAL;
    changing      = eff_mode == lamp_pkg::MODE_TO_LOCAL ||
                    eff_mode == lamp_pkg::MODE_TO_REMOTE;
    // Reports honoured only in the three allowed states
    report_allowed = phase != lamp_pkg::PH_IDLE &&
                     eff_mode == lamp_pkg::MODE_REMOTE &&
                     unit_op_state != lamp_pkg::OPST_OTHER;
  end

  // Per-object operational table from controller reports
  always_ff @(posedge clk) begin
    if (stop) begin
      central_ok <= 1'b0;
      trxc_ok    <= '0;
      rx_ok      <= '0;
      ts_ok      <= '0;
    end else if (clk_en) begin
      if (eff_mode == lamp_pkg::MODE_LOCAL) begin
        // Entering local takes every object out
        central_ok <= 1'b0;
        trxc_ok    <= '0;
        rx_ok      <= '0;
        ts_ok      <= '0;
      end else begin
        if (report_valid && report_allowed &&
            in_range(report.trx, N_TRX) && in_range(report.ts, N_TS)) begin
          unique case (report.kind)
            lamp_pkg::OBJ_CENTRAL: central_ok <= report.operational;
            lamp_pkg::OBJ_TRXC:
              trxc_ok[report.trx] <= report.operational;
            lamp_pkg::OBJ_RX: rx_ok[report.trx] <= report.operational;
            lamp_pkg::OBJ_TS:
              ts_ok[report.trx][report.ts] <= report.operational;
          endcase
        end
        // Object reset is applied last so it wins a clash
        if (obj_reset_valid && in_range(obj_reset.trx, N_TRX) &&
            in_range(obj_reset.ts, N_TS)) begin
          unique case (obj_reset.kind)
            lamp_pkg::OBJ_CENTRAL: central_ok <= 1'b0;
            lamp_pkg::OBJ_TRXC: trxc_ok[obj_reset.trx] <= 1'b0;
            lamp_pkg::OBJ_RX: rx_ok[obj_reset.trx] <= 1'b0;
            lamp_pkg::OBJ_TS: ts_ok[obj_reset.trx][obj_reset.ts] <= 1'b0;
          endcase
        end
      end
    end
  end

  // Acceptance closes each honoured report
  always_ff @(posedge clk) begin
    if (stop) begin
      report_accept <= 1'b0;
    end else if (clk_en) begin
      report_accept <= report_valid && report_allowed;
    end
  end

  // Operational decision per unit kind
  always_comb begin
    remote_master_ok = central_ok && (|trxc_ok) && (|rx_ok) &&
                       any_ts(ts_ok);
    remote_trx_ok    = trxc_ok[0] && rx_ok[0] && (|ts_ok[0]);
    operational      = 1'b0;
    unique case (unit_kind)
      lamp_pkg::KIND_MASTER_CAB: begin
        if (eff_mode == lamp_pkg::MODE_REMOTE) begin
          operational = remote_master_ok;
        end else begin
          operational = local_status.central_fault_free &&
                        (|trxc_fault_free) && local_status.local_cfg_done;
        end
      end
      lamp_pkg::KIND_EXT_CAB, lamp_pkg::KIND_TRX_UNIT: begin
        if (eff_mode == lamp_pkg::MODE_REMOTE) begin
          operational = remote_trx_ok;
        end else begin
          operational = (|trxc_fault_free) && local_status.local_cfg_done;
        end
      end
      lamp_pkg::KIND_SLAVE_TX: operational = master_sync2;
      lamp_pkg::KIND_ENV_UNIT:
        operational = local_status.env_operational;
      lamp_pkg::KIND_SUB_UNIT:
        operational = local_status.sub_fault_free;
      default: operational = 1'b0;
    endcase
    if (changing) begin
      operational = 1'b0;
    end
    any_flash = flash_req.cfg_in_progress || flash_req.sw_receiving ||
                flash_req.restart_pending;
  end

  // Operational lamp: flash over on over off
  always_ff @(posedge clk) begin
    if (stop) begin
      op_lamp <= `LAMP_RST_OFF;
    end else if (clk_en) begin
      unique case (phase)
        lamp_pkg::PH_IDLE:    op_lamp <= `LAMP_RST_OFF;
        lamp_pkg::PH_STARTUP: op_lamp <= `LAMP_RST_ON;
        lamp_pkg::PH_RUN: begin
          if (any_flash) begin
            op_lamp <= flash;
          end else begin
            op_lamp <= operational;
          end
        end
      endcase
    end
  end

  // Disable wins over enable in the same cycle
  always_ff @(posedge clk) begin
    if (stop) begin
      tx_not_enabled_lamp <= `LAMP_RST_OFF;
    end else if (clk_en) begin
      if (phase == lamp_pkg::PH_IDLE) begin
        tx_not_enabled_lamp <= sw_start;
      end else if (tx_disable || eff_mode == lamp_pkg::MODE_LOCAL) begin
        tx_not_enabled_lamp <= 1'b1;
      end else if (tx_enable) begin
        tx_not_enabled_lamp <= 1'b0;
      end
    end
  end

  // Link loss while remote is deliberately not shown
  always_ff @(posedge clk) begin
    if (stop) begin
      local_lamp <= `LAMP_RST_OFF;
    end else if (clk_en) begin
      if (phase == lamp_pkg::PH_IDLE) begin
        local_lamp <= sw_start;
      end else if (!mode_handling_started) begin
        local_lamp <= 1'b1;
      end else begin
        unique case (eff_mode)
          lamp_pkg::MODE_LOCAL:  local_lamp <= 1'b1;
          lamp_pkg::MODE_REMOTE: local_lamp <= 1'b0;
          lamp_pkg::MODE_TO_LOCAL, lamp_pkg::MODE_TO_REMOTE:
            local_lamp <= flash;
        endcase
      end
    end
  end

  sequence s_running;
    clk_en && phase == lamp_pkg::PH_RUN;
  endsequence

  sequence s_start_seen;
    clk_en && phase == lamp_pkg::PH_IDLE && sw_start;
  endsequence

  a_reset_ends_lamps: assert property (
    @(posedge clk) unit_reset |=> !op_lamp && !local_lamp &&
      !tx_not_enabled_lamp && phase == lamp_pkg::PH_IDLE)
    else $error("lamps still driven after unit reset");

  a_start_lamp_test: assert property (
    @(posedge clk) disable iff (stop)
    s_start_seen ##1 (clk_en && !stop) |=> op_lamp)
    else $error("operational lamp not lit during start-up");

  a_accept_reply: assert property (
    @(posedge clk) disable iff (stop)
    clk_en && report_valid && report_allowed |=> report_accept)
    else $error("report not accepted");

  a_refuse_local: assert property (
    @(posedge clk) disable iff (stop)
    clk_en && report_valid && eff_mode != lamp_pkg::MODE_REMOTE
      |=> !report_accept)
    else $error("report accepted outside remote mode");

  a_flash_priority: assert property (
    @(posedge clk) disable iff (stop)
    s_running and any_flash |=> op_lamp == $past(flash))
    else $error("flash request not shown");

  a_change_not_oper: assert property (
    @(posedge clk) disable iff (stop)
    s_running and (changing && !any_flash) |=> !op_lamp)
    else $error("lamp on during mode change");

  a_tx_disable_on: assert property (
    @(posedge clk) disable iff (stop)
    clk_en && phase != lamp_pkg::PH_IDLE && tx_disable
      |=> tx_not_enabled_lamp)
    else $error("tx lamp not lit on disable");

  a_tx_enable_off: assert property (
    @(posedge clk) disable iff (stop)
    clk_en && phase != lamp_pkg::PH_IDLE && tx_enable && !tx_disable &&
      eff_mode != lamp_pkg::MODE_LOCAL |=> !tx_not_enabled_lamp)
    else $error("tx lamp lit while enabled");

  a_local_until_start: assert property (
    @(posedge clk) disable iff (stop)
    clk_en && phase != lamp_pkg::PH_IDLE && !mode_handling_started
      |=> local_lamp)
    else $error("local lamp dark before mode handling");

  a_stay_local: assert property (
    @(posedge clk) disable iff (stop)
    clk_en && phase != lamp_pkg::PH_IDLE &&
      (unit_kind == lamp_pkg::KIND_ENV_UNIT ||
       unit_kind == lamp_pkg::KIND_SUB_UNIT) |=> local_lamp)
    else $error("non-radio unit left local mode");

endmodule

`default_nettype wire

// ---- verification/bsc_model.sv ----
// Behavioural controller that sends operational-information reports.
// Assumes the bench requests one report per send pulse on the shared clock.
`timescale 1ns/10ps
`default_nettype none

module bsc_model (
  input  wire logic                 clk,
  input  wire logic                 send,
  input  wire lamp_pkg::op_report_t msg,
  input  wire logic                 report_accept,
  output logic                      report_valid,
  output lamp_pkg::op_report_t      report,
  output int                        accepts
);
  initial begin
    report_valid = 1'b0;
    report       = '0;
    accepts      = 0;
  end

  // Released bus shows inverted data so stale values never look valid
  always @(posedge clk) begin
    report_valid <= send;
    report       <= send ? msg : ~report;
    if (report_accept === 1'b1)
      accepts <= accepts + 1;
  end
endmodule
`default_nettype wire

// ---- verification/unit_status_indicator_control_test.sv ----
// Self-checking bench for the status lamp controller.
// Assumes short startup and flash counts so the run stays brief.
`timescale 1ns/10ps
`default_nettype none

module unit_status_indicator_control_test;
  typedef struct packed {
    lamp_pkg::unit_kind_t k;
    lamp_pkg::unit_mode_t m;
    logic [3:0]           ls;
    logic [7:0]           tf;
    logic                 op;
  } row_t;

  localparam row_t ROWS [7] = '{
    '{lamp_pkg::KIND_MASTER_CAB, lamp_pkg::MODE_LOCAL,  4'hC, 8'h01, 1'b1},
    '{lamp_pkg::KIND_MASTER_CAB, lamp_pkg::MODE_LOCAL,  4'h4, 8'h01, 1'b0},
    '{lamp_pkg::KIND_MASTER_CAB, lamp_pkg::MODE_LOCAL,  4'hC, 8'h00, 1'b0},
    '{lamp_pkg::KIND_EXT_CAB,    lamp_pkg::MODE_LOCAL,  4'h4, 8'h80, 1'b1},
    '{lamp_pkg::KIND_EXT_CAB,    lamp_pkg::MODE_LOCAL,  4'h0, 8'hFF, 1'b0},
    '{lamp_pkg::KIND_SUB_UNIT,   lamp_pkg::MODE_REMOTE, 4'h2, 8'h00, 1'b1},
    '{lamp_pkg::KIND_ENV_UNIT,   lamp_pkg::MODE_REMOTE, 4'h1, 8'h00, 1'b1}
  };

  logic clk = 1'b0, sys_rst = 1'b1, unit_reset = 1'b0, sw_start = 1'b0;
  logic mh_started = 1'b0, obj_reset_valid = 1'b0, send = 1'b0;
  logic tx_enable = 1'b0, tx_disable = 1'b0, master_lamp_in = 1'b0;
  logic clk_en = 1'b1;
  lamp_pkg::unit_kind_t      unit_kind = lamp_pkg::KIND_MASTER_CAB;
  lamp_pkg::unit_mode_t      unit_mode = lamp_pkg::MODE_LOCAL;
  lamp_pkg::op_state_t       op_state  = lamp_pkg::OPST_A;
  lamp_pkg::op_report_t      msg = '0, obj_reset = '0, report;
  lamp_pkg::flash_req_t      flash_req = '0;
  lamp_pkg::local_status_t   local_status = '0;
  logic [7:0]                trxc_ff = 8'h00;
  logic report_valid, op_lamp, tx_lamp, local_lamp, report_accept;
  int   accepts, fail_count = 0, checked = 0;

  always #4 clk = ~clk;

  bsc_model bsc_u (.clk(clk), .send(send), .msg(msg),
    .report_accept(report_accept), .report_valid(report_valid),
    .report(report), .accepts(accepts));

  unit_status_indicator_control #(.STARTUP_CYCLES(20),
    .FLASH_HALF_CYCLES(4)) dut_u (
    .clk(clk), .clk_en(clk_en), .sys_rst(sys_rst), .unit_reset(unit_reset),
    .sw_start(sw_start), .unit_kind(unit_kind), .unit_mode(unit_mode),
    .mode_handling_started(mh_started), .unit_op_state(op_state),
    .report_valid(report_valid), .report(report),
    .obj_reset_valid(obj_reset_valid), .obj_reset(obj_reset),
    .flash_req(flash_req), .local_status(local_status),
    .trxc_fault_free(trxc_ff), .tx_enable(tx_enable),
    .tx_disable(tx_disable), .master_lamp_in(master_lamp_in),
    .op_lamp(op_lamp), .tx_not_enabled_lamp(tx_lamp),
    .local_lamp(local_lamp), .report_accept(report_accept));

  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: lamp %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp);
    checked++;
    if (got != exp) begin
      fail_count++;
      $display("mismatch at %0t: count %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Both levels must show within 12 cycles of a 4-cycle half period
  task automatic flash_chk(input int sel);
    int ones;
    ones = 0;
    repeat (12) begin
      @(negedge clk);
      if ((sel == 0 ? op_lamp : local_lamp) === 1'b1)
        ones++;
    end
    chk(ones >= 3 && ones <= 9, 1'b1);
  endtask

  task automatic send_rep(input lamp_pkg::obj_kind_t k, input logic [2:0] ts);
    @(posedge clk);
    send <= 1'b1;
    msg  <= '{k, 3'h0, ts, 1'b1};
    @(posedge clk);
    send <= 1'b0;
    step(3);
  endtask

  task automatic start_sw();
    @(posedge clk);
    sw_start <= 1'b1;
    @(posedge clk);
    sw_start <= 1'b0;
    @(negedge clk);
  endtask

  initial begin
    #(8 * 5000);
    fail_count++;
    results();
  end

  initial begin
    step(8);
    @(posedge clk);
    sys_rst <= 1'b0;
    step(0);
    chk(op_lamp | tx_lamp | local_lamp | report_accept, 1'b0);
    start_sw();
    chk(tx_lamp, 1'b1);
    chk(local_lamp, 1'b1);
    step(2);
    chk(op_lamp, 1'b1);
    step(6);
    chk(local_lamp, 1'b1);
    step(20);
    chk(op_lamp, 1'b0);
    @(posedge clk);
    mh_started <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      @(posedge clk);
      unit_kind    <= ROWS[i].k;
      unit_mode    <= ROWS[i].m;
      local_status <= lamp_pkg::local_status_t'(ROWS[i].ls);
      trxc_ff      <= ROWS[i].tf;
      step(3);
      chk(op_lamp, ROWS[i].op);
      chk(local_lamp, 1'b1);
      chk(tx_lamp, 1'b1);
    end
    @(posedge clk);
    unit_kind    <= lamp_pkg::KIND_MASTER_CAB;
    unit_mode    <= lamp_pkg::MODE_REMOTE;
    local_status <= '0;
    trxc_ff      <= 8'h00;
    op_state     <= lamp_pkg::OPST_OTHER;
    step(3);
    chk(local_lamp, 1'b0);
    @(posedge clk);
    tx_enable <= 1'b1;
    @(posedge clk);
    tx_enable <= 1'b0;
    step(2);
    chk(tx_lamp, 1'b0);
    send_rep(lamp_pkg::OBJ_CENTRAL, 3'h0);
    chk_cnt(accepts, 0);
    @(posedge clk);
    op_state <= lamp_pkg::OPST_B;
    send_rep(lamp_pkg::OBJ_CENTRAL, 3'h0);
    send_rep(lamp_pkg::OBJ_TRXC, 3'h0);
    send_rep(lamp_pkg::OBJ_RX, 3'h0);
    chk(op_lamp, 1'b0);
    chk_cnt(accepts, 3);
    send_rep(lamp_pkg::OBJ_TS, 3'h7);
    chk(op_lamp, 1'b1);
    @(posedge clk);
    flash_req <= 3'b100;
    flash_chk(0);
    @(posedge clk);
    flash_req  <= 3'b000;
    tx_disable <= 1'b1;
    obj_reset_valid <= 1'b1;
    obj_reset  <= '{lamp_pkg::OBJ_TS, 3'h0, 3'h7, 1'b0};
    @(posedge clk);
    tx_disable <= 1'b0;
    obj_reset_valid <= 1'b0;
    step(3);
    chk(tx_lamp, 1'b1);
    chk(op_lamp, 1'b0);
    send_rep(lamp_pkg::OBJ_TS, 3'h2);
    chk(op_lamp, 1'b1);
    @(posedge clk);
    unit_mode <= lamp_pkg::MODE_TO_LOCAL;
    step(3);
    chk(op_lamp, 1'b0);
    flash_chk(1);
    @(posedge clk);
    unit_mode <= lamp_pkg::MODE_LOCAL;
    step(3);
    send_rep(lamp_pkg::OBJ_CENTRAL, 3'h0);
    chk_cnt(accepts, 5);
    @(posedge clk);
    unit_mode <= lamp_pkg::MODE_REMOTE;
    step(3);
    chk(op_lamp, 1'b0);
    @(posedge clk);
    unit_kind      <= lamp_pkg::KIND_SLAVE_TX;
    master_lamp_in <= 1'b1;
    step(6);
    chk(op_lamp, 1'b1);
    @(posedge clk);
    master_lamp_in <= 1'b0;
    clk_en         <= 1'b0;
    step(6);
    // Frozen clock enable must hold the lit lamp while master_lamp_in falls
    chk(op_lamp, 1'b1);
    @(posedge clk);
    clk_en <= 1'b1;
    step(6);
    chk(op_lamp, 1'b0);
    @(posedge clk);
    unit_reset <= 1'b1;
    @(posedge clk);
    unit_reset <= 1'b0;
    step(1);
    chk(op_lamp | tx_lamp | local_lamp, 1'b0);
    start_sw();
    chk(tx_lamp, 1'b1);
    results();
  end
endmodule
`default_nettype wire
